// >>> design/slbr_pkg.sv
// Purpose: Shared constants and types of the security length, supply
//          monitor and pin configuration register bank.
// Assumes: 16-bit registers reached by a 6-bit register address.
// Notes:   Every offset, field position and reset value lives here.
package slbr_pkg;

   // Register addresses.
   localparam logic [5:0] SLBR_ADDR_SEC_LEN   = 6'h1A;
   localparam logic [5:0] SLBR_ADDR_SUPPLY    = 6'h1B;
   localparam logic [5:0] SLBR_ADDR_PIN_CFG   = 6'h1C;

   // Length register fields.
   localparam int SLBR_TXL_LSB = 8;
   localparam int SLBR_TXL_MSB = 14;
   localparam int SLBR_RXL_LSB = 0;
   localparam int SLBR_RXL_MSB = 6;
   localparam logic [6:0] SLBR_TXL_RESET = 7'h00;
   localparam logic [6:0] SLBR_RXL_RESET = 7'h00;

   // Supply monitor register fields.
   localparam int SLBR_SUP_OK_BIT   = 6;
   localparam int SLBR_SUP_EN_BIT   = 5;
   localparam int SLBR_SUP_CODE_LSB = 0;
   localparam int SLBR_SUP_CODE_MSB = 4;
   localparam logic       SLBR_SUP_OK_RESET   = 1'b1;
   localparam logic       SLBR_SUP_EN_RESET   = 1'b0;
   localparam logic [4:0] SLBR_SUP_CODE_RESET = 5'h00;

   // Pin configuration register fields.
   localparam int SLBR_BCN_BIT      = 11;
   localparam int SLBR_RXDP_POL_BIT = 10;
   localparam int SLBR_THR_POL_BIT  = 9;
   localparam int SLBR_SFD_POL_BIT  = 8;
   localparam int SLBR_CCA_POL_BIT  = 7;
   localparam int SLBR_THR_LSB      = 0;
   localparam int SLBR_THR_MSB      = 6;
   localparam logic       SLBR_POL_RESET = 1'b0;
   localparam logic       SLBR_BCN_RESET = 1'b0;
   localparam logic [6:0] SLBR_THR_RESET = 7'h40;

   localparam logic [15:0] SLBR_ZERO16 = 16'h0000;
   localparam logic [6:0]  SLBR_ZERO7  = 7'h00;

   // In-line cipher modes.
   typedef enum logic [1:0] {
      SLBR_MODE_OFF    = 2'h0,
      SLBR_MODE_CBCMAC = 2'h1,
      SLBR_MODE_CTR    = 2'h2,
      SLBR_MODE_CCM    = 2'h3
   } slbr_mode_t;

   // Internal active-high status signals that feed the pins.
   typedef struct packed {
      logic rx_data_present;
      logic rx_threshold;
      logic frame_delim;
      logic channel_clear;
   } slbr_pins_t;

   // Offsets handed to the cipher engine for one direction.
   typedef struct packed {
      logic [6:0] crypt_skip;
      logic [6:0] auth_skip;
      logic [6:0] auth_only;
   } slbr_len_t;

endpackage

// >>> design/slbr_regs.sv
// Purpose: Security length, supply monitor and pin configuration registers.
// Assumes: One clock, synchronous active-low reset, synchronous inputs.
// Notes:   Reads answer one cycle after the read strobe.
//
// Contract
// - Transmit length field in bits 14:8 steers CTR and CBC-MAC offsets.
// - Stand-alone cipher operations ignore the transmit length field.
// - Receive length field in bits 6:0 steers CTR and CBC-MAC offsets.
// - Stand-alone cipher operations ignore the receive length field.
// - Comparator result is read-only bit 6, resets to 1.
// - Result reads 0 below the trip level, 1 above it.
// - Bit 5 switches the supply monitor on, reset 0.
// - Bits 4:0 hold the trip-level code, reset 0.
// - With filtering on, bit 11 accepts all beacons or only PAN matches.
// - Beacon acceptance bit has no effect while filtering is off.
// - Bit 10 inverts the receive-data-present output, reset 0.
// - Bit 9 inverts the receive-threshold output, reset 0.
// - Bit 8 inverts the frame delimiter pin, reset 0.
// - Bit 7 inverts the channel clear pin, reset 0.
// - Bits 6:0 hold receive threshold, reset 64; flag when count reaches it.
// - Cipher mode 0 off, 1 CBC-MAC, 2 counter, 3 CCM.
`timescale 1ns/100ps
module slbr_regs (
   // Clock and reset.
   input  wire logic                clk_in,
   input  wire logic                rst_n_in,
   // Register port.
   input  wire logic [5:0]          reg_addr_in,
   input  wire logic                reg_wr_in,
   input  wire logic                reg_rd_in,
   input  wire logic [15:0]         reg_wdata_in,
   output logic      [15:0]         reg_rdata_out,
   // Cipher engine side.
   input  wire slbr_pkg::slbr_mode_t inline_cipher_mode_in,
   input  wire logic                standalone_active_in,
   output slbr_pkg::slbr_len_t      tx_len_out,
   output slbr_pkg::slbr_len_t      rx_len_out,
   // Supply comparator side.
   input  wire logic                supply_cmp_above_in,
   output logic                     supply_monitor_on_out,
   output logic      [4:0]          supply_trip_code_out,
   // Frame filter side.
   input  wire logic                addr_filter_en_in,
   input  wire logic                beacon_frame_in,
   input  wire logic                src_pan_match_in,
   output logic                     beacon_accept_out,
   // Status pins.
   input  wire slbr_pkg::slbr_pins_t status_in,
   input  wire logic [7:0]          rx_fill_count_in,
   output slbr_pkg::slbr_pins_t     pins_out
);

   logic [6:0]           tx_cleartext_len_reg;
   logic [6:0]           rx_cleartext_len_reg;
   logic                 supply_above_trip_reg;
   logic                 supply_monitor_on_reg;
   logic [4:0]           supply_trip_code_reg;
   logic                 any_pan_beacon_accept_reg;
   logic                 rx_data_present_invert_reg;
   logic                 rx_threshold_invert_reg;
   logic                 frame_delim_invert_reg;
   logic                 channel_clear_invert_reg;
   logic [6:0]           rx_threshold_level_reg;
   logic [15:0]          rdata_next;
   slbr_pkg::slbr_len_t  tx_len_next;
   slbr_pkg::slbr_len_t  rx_len_next;
   slbr_pkg::slbr_pins_t status_now;
   logic                 wr_len;
   logic                 wr_sup;
   logic                 wr_pin;

   assign wr_len = reg_wr_in && (reg_addr_in == slbr_pkg::SLBR_ADDR_SEC_LEN);
   assign wr_sup = reg_wr_in && (reg_addr_in == slbr_pkg::SLBR_ADDR_SUPPLY);
   assign wr_pin = reg_wr_in && (reg_addr_in == slbr_pkg::SLBR_ADDR_PIN_CFG);

   // Only the writable fields are taken; reserved write bits are dropped.
   always_ff @(posedge clk_in) begin
      if (!rst_n_in) begin
         tx_cleartext_len_reg <= slbr_pkg::SLBR_TXL_RESET;
         rx_cleartext_len_reg <= slbr_pkg::SLBR_RXL_RESET;
      end else if (wr_len) begin
         tx_cleartext_len_reg <= reg_wdata_in[slbr_pkg::SLBR_TXL_MSB:
                                              slbr_pkg::SLBR_TXL_LSB];
         rx_cleartext_len_reg <= reg_wdata_in[slbr_pkg::SLBR_RXL_MSB:
                                              slbr_pkg::SLBR_RXL_LSB];
      end
   end

   always_ff @(posedge clk_in) begin
      if (!rst_n_in) begin
         supply_monitor_on_reg <= slbr_pkg::SLBR_SUP_EN_RESET;
         supply_trip_code_reg  <= slbr_pkg::SLBR_SUP_CODE_RESET;
      end else if (wr_sup) begin
         supply_monitor_on_reg <= reg_wdata_in[slbr_pkg::SLBR_SUP_EN_BIT];
         supply_trip_code_reg  <= reg_wdata_in[slbr_pkg::SLBR_SUP_CODE_MSB:
                                              slbr_pkg::SLBR_SUP_CODE_LSB];
      end
   end

   // The comparator is only trusted while it runs, so a disabled monitor
   // keeps the last result rather than reporting a floating output.
   always_ff @(posedge clk_in) begin
      if (!rst_n_in) begin
         supply_above_trip_reg <= slbr_pkg::SLBR_SUP_OK_RESET;
      end else if (supply_monitor_on_reg) begin
         supply_above_trip_reg <= supply_cmp_above_in;
      end
   end

   always_ff @(posedge clk_in) begin
      if (!rst_n_in) begin
         any_pan_beacon_accept_reg  <= slbr_pkg::SLBR_BCN_RESET;
         rx_data_present_invert_reg <= slbr_pkg::SLBR_POL_RESET;
         rx_threshold_invert_reg    <= slbr_pkg::SLBR_POL_RESET;
         frame_delim_invert_reg     <= slbr_pkg::SLBR_POL_RESET;
         channel_clear_invert_reg   <= slbr_pkg::SLBR_POL_RESET;
         rx_threshold_level_reg     <= slbr_pkg::SLBR_THR_RESET;
      end else if (wr_pin) begin
         any_pan_beacon_accept_reg  <= reg_wdata_in[slbr_pkg::SLBR_BCN_BIT];
         rx_data_present_invert_reg <=
            reg_wdata_in[slbr_pkg::SLBR_RXDP_POL_BIT];
         rx_threshold_invert_reg    <=
            reg_wdata_in[slbr_pkg::SLBR_THR_POL_BIT];
         frame_delim_invert_reg     <=
            reg_wdata_in[slbr_pkg::SLBR_SFD_POL_BIT];
         channel_clear_invert_reg   <=
            reg_wdata_in[slbr_pkg::SLBR_CCA_POL_BIT];
         rx_threshold_level_reg     <= reg_wdata_in[slbr_pkg::SLBR_THR_MSB:
                                              slbr_pkg::SLBR_THR_LSB];
      end
   end

   // Read data; reserved and unmapped bits return zero.
   always_comb begin
      rdata_next = slbr_pkg::SLBR_ZERO16;
      unique case (reg_addr_in)
         slbr_pkg::SLBR_ADDR_SEC_LEN: begin
            rdata_next[slbr_pkg::SLBR_TXL_MSB:slbr_pkg::SLBR_TXL_LSB] =
               tx_cleartext_len_reg;
            rdata_next[slbr_pkg::SLBR_RXL_MSB:slbr_pkg::SLBR_RXL_LSB] =
               rx_cleartext_len_reg;
         end
         slbr_pkg::SLBR_ADDR_SUPPLY: begin
            rdata_next[slbr_pkg::SLBR_SUP_OK_BIT] = supply_above_trip_reg;
            rdata_next[slbr_pkg::SLBR_SUP_EN_BIT] = supply_monitor_on_reg;
            rdata_next[slbr_pkg::SLBR_SUP_CODE_MSB:
                       slbr_pkg::SLBR_SUP_CODE_LSB] = supply_trip_code_reg;
         end
         slbr_pkg::SLBR_ADDR_PIN_CFG: begin
            rdata_next[slbr_pkg::SLBR_BCN_BIT]      = any_pan_beacon_accept_reg;
            rdata_next[slbr_pkg::SLBR_RXDP_POL_BIT] = rx_data_present_invert_reg;
            rdata_next[slbr_pkg::SLBR_THR_POL_BIT]  = rx_threshold_invert_reg;
            rdata_next[slbr_pkg::SLBR_SFD_POL_BIT]  = frame_delim_invert_reg;
            rdata_next[slbr_pkg::SLBR_CCA_POL_BIT]  = channel_clear_invert_reg;
            rdata_next[slbr_pkg::SLBR_THR_MSB:slbr_pkg::SLBR_THR_LSB] =
               rx_threshold_level_reg;
         end
         default: begin
            rdata_next = slbr_pkg::SLBR_ZERO16;
         end
      endcase
   end

   always_ff @(posedge clk_in) begin
      if (!rst_n_in) begin
         reg_rdata_out <= slbr_pkg::SLBR_ZERO16;
      end else if (reg_rd_in) begin
         reg_rdata_out <= rdata_next;
      end
   end

   // Each mode sees only its own interpretation; the rest read as zero.
   always_comb begin
      tx_len_next = '0;
      rx_len_next = '0;
      if (!standalone_active_in) begin
         unique case (inline_cipher_mode_in)
            slbr_pkg::SLBR_MODE_OFF: begin
               tx_len_next = '0;
            end
            slbr_pkg::SLBR_MODE_CBCMAC: begin
               tx_len_next.auth_skip = tx_cleartext_len_reg;
               rx_len_next.auth_skip = rx_cleartext_len_reg;
            end
            slbr_pkg::SLBR_MODE_CTR: begin
               tx_len_next.crypt_skip = tx_cleartext_len_reg;
               rx_len_next.crypt_skip = rx_cleartext_len_reg;
            end
            slbr_pkg::SLBR_MODE_CCM: begin
               tx_len_next.auth_only = tx_cleartext_len_reg;
               rx_len_next.auth_only = rx_cleartext_len_reg;
            end
         endcase
      end
   end

   always_ff @(posedge clk_in) begin
      if (!rst_n_in) begin
         tx_len_out <= '0;
         rx_len_out <= '0;
      end else begin
         tx_len_out <= tx_len_next;
         rx_len_out <= rx_len_next;
      end
   end

   always_ff @(posedge clk_in) begin
      if (!rst_n_in) begin
         supply_monitor_on_out <= slbr_pkg::SLBR_SUP_EN_RESET;
         supply_trip_code_out  <= slbr_pkg::SLBR_SUP_CODE_RESET;
      end else begin
         supply_monitor_on_out <= supply_monitor_on_reg;
         supply_trip_code_out  <= supply_trip_code_reg;
      end
   end

   // Beacon acceptance; the policy bit matters only while filtering.
   always_ff @(posedge clk_in) begin
      if (!rst_n_in) begin
         beacon_accept_out <= 1'b0;
      end else begin
         beacon_accept_out <= beacon_frame_in && (!addr_filter_en_in ||
            any_pan_beacon_accept_reg || src_pan_match_in);
      end
   end

   // The fill count is one bit wider so a full buffer still compares.
   always_comb begin
      status_now              = status_in;
      status_now.rx_threshold = rx_fill_count_in >=
                                {1'b0, rx_threshold_level_reg};
   end

   always_ff @(posedge clk_in) begin
      if (!rst_n_in) begin
         pins_out <= '0;
      end else begin
         pins_out.rx_data_present <= status_now.rx_data_present ^
                                     rx_data_present_invert_reg;
         pins_out.rx_threshold    <= status_now.rx_threshold ^
                                     rx_threshold_invert_reg;
         pins_out.frame_delim     <= status_now.frame_delim ^
                                     frame_delim_invert_reg;
         pins_out.channel_clear   <= status_now.channel_clear ^
                                     channel_clear_invert_reg;
      end
   end

   AST_TXL_CTR: assert property (@(posedge clk_in) disable iff (!rst_n_in)
      !standalone_active_in && inline_cipher_mode_in ==
      slbr_pkg::SLBR_MODE_CTR |=> tx_len_out.crypt_skip ==
      $past(tx_cleartext_len_reg)) else $error("Transmit CTR offset wrong.");

   AST_TXL_CCM: assert property (@(posedge clk_in) disable iff (!rst_n_in)
      !standalone_active_in && inline_cipher_mode_in ==
      slbr_pkg::SLBR_MODE_CCM |=> tx_len_out.auth_only ==
      $past(tx_cleartext_len_reg) && tx_len_out.crypt_skip ==
      slbr_pkg::SLBR_ZERO7) else $error("Transmit CCM length wrong.");

   AST_STANDALONE: assert property (@(posedge clk_in) disable iff (!rst_n_in)
      standalone_active_in |=> tx_len_out == '0 && rx_len_out == '0)
      else $error("Length used in stand-alone operation.");

   AST_RXL_CBC: assert property (@(posedge clk_in) disable iff (!rst_n_in)
      !standalone_active_in && inline_cipher_mode_in ==
      slbr_pkg::SLBR_MODE_CBCMAC |=> rx_len_out.auth_skip ==
      $past(rx_cleartext_len_reg)) else $error("Receive CBC offset wrong.");

   AST_OK_READONLY: assert property (@(posedge clk_in) disable iff (!rst_n_in)
      wr_sup && !supply_monitor_on_reg |=> $stable(supply_above_trip_reg))
      else $error("Write altered comparator result.");

   AST_OK_TRACK: assert property (@(posedge clk_in) disable iff (!rst_n_in)
      supply_monitor_on_reg |=> supply_above_trip_reg ==
      $past(supply_cmp_above_in)) else $error("Result does not track.");

   AST_SUP_EN: assert property (@(posedge clk_in) disable iff (!rst_n_in)
      wr_sup |-> ##2 supply_monitor_on_out ==
      $past(reg_wdata_in[slbr_pkg::SLBR_SUP_EN_BIT], 2))
      else $error("Monitor enable not applied.");

   AST_BEACON: assert property (@(posedge clk_in) disable iff (!rst_n_in)
      beacon_frame_in && !addr_filter_en_in |=> beacon_accept_out)
      else $error("Beacon refused while filter off.");

   AST_THRESH: assert property (@(posedge clk_in) disable iff (!rst_n_in)
      !rx_threshold_invert_reg && rx_fill_count_in <
      {1'b0, rx_threshold_level_reg} |=> !pins_out.rx_threshold)
      else $error("Threshold flag early.");

   AST_POLARITY: assert property (@(posedge clk_in) disable iff (!rst_n_in)
      wr_pin ##1 !wr_pin |=> pins_out.channel_clear ==
      ($past(status_in.channel_clear) ^ channel_clear_invert_reg))
      else $error("Clear channel polarity wrong.");

   AST_RESERVED: assert property (@(posedge clk_in) disable iff (!rst_n_in)
      reg_rd_in && reg_addr_in == slbr_pkg::SLBR_ADDR_SUPPLY |=>
      reg_rdata_out[15:7] == 9'h000) else $error("Reserved bits nonzero.");

   // Unmapped addresses must not leak a neighbour's contents.
   AST_RD_UNMAPPED: assert property (
      @(posedge clk_in) disable iff (!rst_n_in)
      reg_rd_in && reg_addr_in > slbr_pkg::SLBR_ADDR_PIN_CFG |=>
      reg_rdata_out == slbr_pkg::SLBR_ZERO16)
      else $error("Unmapped read nonzero.");

   AST_RXL_CTR: assert property (
      @(posedge clk_in) disable iff (!rst_n_in)
      !standalone_active_in && inline_cipher_mode_in ==
      slbr_pkg::SLBR_MODE_CTR |=> rx_len_out.crypt_skip ==
      $past(rx_cleartext_len_reg)) else $error("Receive CTR offset wrong.");

   AST_RXL_CCM: assert property (
      @(posedge clk_in) disable iff (!rst_n_in)
      !standalone_active_in && inline_cipher_mode_in ==
      slbr_pkg::SLBR_MODE_CCM |=> rx_len_out.auth_only ==
      $past(rx_cleartext_len_reg) && rx_len_out.auth_skip ==
      slbr_pkg::SLBR_ZERO7) else $error("Receive CCM length wrong.");

   AST_MODE_OFF: assert property (
      @(posedge clk_in) disable iff (!rst_n_in)
      inline_cipher_mode_in == slbr_pkg::SLBR_MODE_OFF |=>
      tx_len_out == '0 && rx_len_out == '0)
      else $error("Length used with security off.");

   AST_TRIP_CODE: assert property (
      @(posedge clk_in) disable iff (!rst_n_in)
      wr_sup |=> supply_trip_code_reg ==
      $past(reg_wdata_in[slbr_pkg::SLBR_SUP_CODE_MSB:
                         slbr_pkg::SLBR_SUP_CODE_LSB]))
      else $error("Trip code not stored.");

   AST_BEACON_POLICY: assert property (
      @(posedge clk_in) disable iff (!rst_n_in)
      beacon_frame_in && addr_filter_en_in && !any_pan_beacon_accept_reg &&
      !src_pan_match_in |=> !beacon_accept_out)
      else $error("Foreign beacon accepted.");

   AST_RXDP_POL: assert property (
      @(posedge clk_in) disable iff (!rst_n_in)
      1'b1 |=> pins_out.rx_data_present ==
      ($past(status_in.rx_data_present) ^ $past(rx_data_present_invert_reg)))
      else $error("Data present polarity wrong.");

   AST_THR_POL: assert property (
      @(posedge clk_in) disable iff (!rst_n_in)
      1'b1 |=> pins_out.rx_threshold ==
      ($past(rx_fill_count_in >= {1'b0, rx_threshold_level_reg}) ^
       $past(rx_threshold_invert_reg)))
      else $error("Threshold polarity wrong.");

   AST_SFD_POL: assert property (
      @(posedge clk_in) disable iff (!rst_n_in)
      1'b1 |=> pins_out.frame_delim ==
      ($past(status_in.frame_delim) ^ $past(frame_delim_invert_reg)))
      else $error("Frame delimiter polarity wrong.");

endmodule

// >>> dv/slbr_host_model.sv
// Purpose: Host model driving the register port of the bank.
// Assumes: Strobes are one-cycle pulses launched just after a rising edge.
// Notes:   Reserved bits of mapped registers are cleared here; writes to unmapped addresses keep every bit.
`timescale 1ns/100ps
module slbr_host_model (
   // Clock.
   input  wire logic        clk_in,
   // Register port.
   input  wire logic [15:0] rdata_in,
   output logic      [5:0]  addr_out,
   output logic             wr_out,
   output logic             rd_out,
   output logic      [15:0] wdata_out
);
   // Comparator settling time of 5 us at 200 MHz.
   localparam int SETTLE_CYCLES = 1000;

   initial begin
      addr_out  = 6'h00;
      wr_out    = 1'b0;
      rd_out    = 1'b0;
      wdata_out = 16'h0000;
   end

   function automatic logic [15:0] legal_mask(input logic [5:0] a);
      case (a)
         slbr_pkg::SLBR_ADDR_SEC_LEN: legal_mask = 16'h7F7F;
         slbr_pkg::SLBR_ADDR_SUPPLY:  legal_mask = 16'h007F;
         slbr_pkg::SLBR_ADDR_PIN_CFG: legal_mask = 16'h0FFF;
         default:                     legal_mask = 16'hFFFF;
      endcase
   endfunction

   task automatic write(input logic [5:0] a, input logic [15:0] d);
      @(posedge clk_in);
      addr_out  <= a;
      wdata_out <= d & legal_mask(a);
      wr_out    <= 1'b1;
      @(posedge clk_in);
      wr_out    <= 1'b0;
   endtask

   task automatic read(input logic [5:0] a, output logic [15:0] d);
      @(posedge clk_in);
      addr_out <= a;
      rd_out   <= 1'b1;
      @(posedge clk_in);
      rd_out   <= 1'b0;
      @(posedge clk_in);
      d = rdata_in;
   endtask

   // The result bit is only trusted once the comparator has settled.
   task automatic program_supply(input logic [15:0] d);
      write(slbr_pkg::SLBR_ADDR_SUPPLY, d);
      repeat (SETTLE_CYCLES) @(posedge clk_in);
   endtask

   task automatic set_cfg(input logic [11:0] pan, input logic [3:0] pol,
                          input logic [6:0] thr);
      write(slbr_pkg::SLBR_ADDR_PIN_CFG,
            {4'h0, (pan == 12'hFFF), pol, thr});
   endtask
endmodule

// >>> dv/testbench.sv
// Purpose: Self-checking bench of the length, supply and pin register bank.
// Assumes: Host model issues all register traffic.
// Notes:   Side outputs are checked two edges after their inputs change.
`timescale 1ns/100ps
module testbench;
   logic                 clk_in;
   logic                 rst_n_in;
   logic [5:0]           addr;
   logic                 wr;
   logic                 rd;
   logic [15:0]          wdata;
   logic [15:0]          rdata;
   logic [15:0]          rd_val;
   slbr_pkg::slbr_mode_t mode;
   logic                 sa;
   logic                 cmp;
   logic                 mon_on;
   logic [4:0]           code;
   logic                 filt;
   logic                 frame;
   logic                 match;
   logic                 bcn_acc;
   slbr_pkg::slbr_pins_t status;
   slbr_pkg::slbr_pins_t pins;
   logic [7:0]           fill;
   slbr_pkg::slbr_len_t  tx_len;
   slbr_pkg::slbr_len_t  rx_len;
   int                   err_total;
   int                   comparisons;
   logic [6:0]           thr_t[5]  = '{7'h05, 7'h05, 7'h05, 7'h7F, 7'h7F};
   logic [7:0]           fill_t[5] = '{8'h04, 8'h05, 8'h06, 8'h7E, 8'h80};

   slbr_regs dut (.clk_in(clk_in), .rst_n_in(rst_n_in), .reg_addr_in(addr),
      .reg_wr_in(wr), .reg_rd_in(rd), .reg_wdata_in(wdata),
      .reg_rdata_out(rdata), .inline_cipher_mode_in(mode),
      .standalone_active_in(sa), .tx_len_out(tx_len), .rx_len_out(rx_len),
      .supply_cmp_above_in(cmp), .supply_monitor_on_out(mon_on),
      .supply_trip_code_out(code), .addr_filter_en_in(filt),
      .beacon_frame_in(frame), .src_pan_match_in(match),
      .beacon_accept_out(bcn_acc), .status_in(status),
      .rx_fill_count_in(fill), .pins_out(pins));

   slbr_host_model host (.clk_in(clk_in), .rdata_in(rdata), .addr_out(addr),
      .wr_out(wr), .rd_out(rd), .wdata_out(wdata));

   initial begin
      clk_in = 1'b0;
      forever #2.5 clk_in = ~clk_in;
   end

   task automatic stop_test();
      $display("TB: errors=%0d comparisons=%0d", err_total, comparisons);
      if (err_total == 0 && comparisons > 0) begin
         $display("TB: PASS");
      end else begin
         $display("TB: FAIL");
      end
      $finish;
   endtask

   task automatic chk_reg(input logic [5:0] a, input logic [15:0] exp);
      host.read(a, rd_val);
      comparisons++;
      if (rd_val !== exp) begin
         err_total++;
         $display("MISMATCH %0t reg %h got %h exp %h", $time, a, rd_val, exp);
      end
   endtask

   task automatic chk_out(input logic [20:0] got, input logic [20:0] exp);
      comparisons++;
      if (got !== exp) begin
         err_total++;
         $display("MISMATCH %0t output got %h exp %h", $time, got, exp);
      end
   endtask

   task automatic settle();
      repeat (2) @(posedge clk_in);
      #1;
   endtask

   function automatic slbr_pkg::slbr_len_t exp_len(input int m,
                                                   input logic s,
                                                   input logic [6:0] l);
      exp_len = '0;
      if (!s && m == 1) exp_len.auth_skip = l;
      if (!s && m == 2) exp_len.crypt_skip = l;
      if (!s && m == 3) exp_len.auth_only = l;
   endfunction

   // A hung run is cut short and reported as a failure.
   initial begin
      repeat (100000) @(posedge clk_in);
      err_total++;
      stop_test();
   end

   initial begin
      err_total = 0;
      comparisons = 0;
      rst_n_in = 1'b0;
      mode = slbr_pkg::SLBR_MODE_OFF;
      sa = 1'b0;
      cmp = 1'b0;
      filt = 1'b0;
      frame = 1'b0;
      match = 1'b0;
      status = 4'h0;
      fill = 8'h00;
      repeat (8) @(posedge clk_in);
      rst_n_in <= 1'b1;
      chk_reg(slbr_pkg::SLBR_ADDR_SEC_LEN, 16'h0000);
      chk_reg(slbr_pkg::SLBR_ADDR_SUPPLY, 16'h0040);
      chk_reg(slbr_pkg::SLBR_ADDR_PIN_CFG, 16'h0040);
      chk_reg(6'h1D, 16'h0000);
      host.write(slbr_pkg::SLBR_ADDR_SEC_LEN, 16'h3A55);
      host.write(6'h1D, 16'hFFFF);
      chk_reg(6'h1D, 16'h0000);
      chk_reg(slbr_pkg::SLBR_ADDR_SEC_LEN, 16'h3A55);
      for (int m = 0; m < 4; m++) begin
         for (int s = 0; s < 2; s++) begin
            @(posedge clk_in);
            mode <= slbr_pkg::slbr_mode_t'(m[1:0]);
            sa <= s[0];
            settle();
            chk_out(tx_len, exp_len(m, s[0], 7'h3A));
            chk_out(rx_len, exp_len(m, s[0], 7'h55));
         end
      end
      host.program_supply(16'h0035);
      chk_reg(slbr_pkg::SLBR_ADDR_SUPPLY, 16'h0035);
      chk_out({15'h0, mon_on, code}, {15'h0, 1'b1, 5'h15});
      @(posedge clk_in);
      cmp <= 1'b1;
      settle();
      chk_reg(slbr_pkg::SLBR_ADDR_SUPPLY, 16'h0075);
      host.program_supply(16'h0020);
      chk_reg(slbr_pkg::SLBR_ADDR_SUPPLY, 16'h0060);
      @(posedge clk_in);
      cmp <= 1'b0;
      host.program_supply(16'h0060);
      chk_reg(slbr_pkg::SLBR_ADDR_SUPPLY, 16'h0020);
      host.write(slbr_pkg::SLBR_ADDR_SUPPLY, 16'h0000);
      @(posedge clk_in);
      cmp <= 1'b1;
      settle();
      chk_reg(slbr_pkg::SLBR_ADDR_SUPPLY, 16'h0000);
      chk_out({15'h0, mon_on, code}, 21'h0);
      for (int b = 0; b < 2; b++) begin
         host.set_cfg(b[0] ? 12'hFFF : 12'h123, 4'h0, 7'h40);
         chk_reg(slbr_pkg::SLBR_ADDR_PIN_CFG, {4'h0, b[0], 11'h040});
         for (int c = 0; c < 8; c++) begin
            @(posedge clk_in);
            {filt, match, frame} <= c[2:0];
            settle();
            chk_out({20'h0, bcn_acc},
                    {20'h0, c[0] & (!c[2] | b[0] | c[1])});
         end
      end
      @(posedge clk_in);
      status <= 4'hF;
      fill <= 8'h05;
      for (int p = 0; p < 16; p++) begin
         host.set_cfg(12'h000, p[3:0], 7'h05);
         settle();
         chk_out({17'h0, pins}, {17'h0, 4'hF ^ p[3:0]});
      end
      // Polarity must show exactly one edge after the write edge.
      host.set_cfg(12'h000, 4'h0, 7'h05);
      #1;
      chk_out({17'h0, pins}, {17'h0, 4'h0});
      @(posedge clk_in);
      #1;
      chk_out({17'h0, pins}, {17'h0, 4'hF});
      for (int t = 0; t < 5; t++) begin
         host.set_cfg(12'h000, 4'h0, thr_t[t]);
         @(posedge clk_in);
         fill <= fill_t[t];
         settle();
         chk_out({20'h0, pins.rx_threshold},
                 {20'h0, fill_t[t] >= {1'b0, thr_t[t]}});
      end
      stop_test();
   end
endmodule
